/* File: core/plbm_consts.vh */
// constants for the pair load and bit move execution block
// assumes a 4-bit core with 8-bit data memory addresses and 100 MHz core_clk
`ifndef PLBM_CONSTS_VH
`define PLBM_CONSTS_VH

// ======================================================================
// opcode first bytes
`define PLBM_OP_EXT 8'hDC
`define PLBM_OP_EA_DA 8'hCE
`define PLBM_OP_DA_EA 8'hCD
`define PLBM_OP_HL_A 8'hC4
`define PLBM_OP_BIT_TOMEM 8'hFC
`define PLBM_OP_BIT_TOC 8'hF4

// ======================================================================
// second byte codes behind the extension byte
`define PLBM_EXT_EA_HL 8'h08
`define PLBM_EXT_HL_EA 8'h00
`define PLBM_EXT_PAIR_HI 4'hF

// ======================================================================
// bit-move second byte forms
`define PLBM_BM_MEMA_TOP 2'h1
`define PLBM_BM_MEMB_TOP 4'h4
`define PLBM_MEMA_HI_A 4'hF
`define PLBM_MEMA_LO_A 4'hB
`define PLBM_MEMA_HI_B 4'hF
`define PLBM_MEMA_LO_B 4'hF

// ======================================================================
// pair select codes (second byte bits 2..1)
`define PLBM_PAIR_EA 2'h0
`define PLBM_PAIR_HL 2'h1
`define PLBM_PAIR_WX 2'h2
`define PLBM_PAIR_YZ 2'h3

`endif

/* File: core/plbm_nib_mem.v */
// small nibble data memory with registered read data
// assumes a single clock; write and read may occur in the same cycle
`timescale 1ns/10ps
module plbm_nib_mem #(
    parameter AW = 8,
    parameter DW = 4
) (
    input wire core_clk,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [DW-1:0] rd_data_q
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge core_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_q <= mem[rd_addr];
    end
endmodule // plbm_nib_mem

/* File: core/plbm_exec.v */
// executes register-pair moves and carry bit moves of a 4-bit core
// assumes instruction bytes arrive as a two-byte pair with a start pulse,
// and that data memory and port space share one nibble address space
`timescale 1ns/10ps
`include "plbm_consts.vh"
module plbm_exec (
    input wire core_clk,
    input wire nrst,
    input wire start,
    input wire [7:0] byte1,
    input wire [7:0] byte2,
    output wire busy,
    output reg done_q,
    output reg illegal_q,
    output reg [7:0] wide_accumulator_q,
    output reg [7:0] primary_pointer_pair_q,
    output reg [7:0] second_pointer_pair_q,
    output reg [7:0] third_pointer_pair_q,
    output reg carry_q,
    input wire mem_wr_en,
    input wire [7:0] mem_wr_addr,
    input wire [3:0] mem_wr_data,
    input wire [7:0] mem_rd_addr,
    output wire [3:0] mem_rd_data
);
    // ======================================================================
    // states
    localparam S_IDLE = 3'h0;
    localparam S_LD1 = 3'h1;
    localparam S_LD2 = 3'h2;
    localparam S_ST2 = 3'h3;
    localparam S_BIT = 3'h4;

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [7:0] addr_q;
    reg [2:0] bit_q;
    reg to_mem_q;

    reg m_we;
    reg [7:0] m_wa;
    reg [3:0] m_wd;
    reg [7:0] m_ra;
    wire [3:0] m_rd;

    assign busy = (state_q != S_IDLE);
    assign mem_rd_data = m_rd;

    plbm_nib_mem #(.AW(8), .DW(4)) u_mem (
        .core_clk(core_clk),
        .wr_en(m_we),
        .wr_addr(m_wa),
        .wr_data(m_wd),
        .rd_addr(m_ra),
        .rd_data_q(m_rd)
    );

    // ======================================================================
    // decode helpers
    wire [7:0] hl_even = {primary_pointer_pair_q[7:1], 1'b0};
    wire [7:0] da_even = {byte2[7:1], 1'b0};
    wire is_ext = (byte1 == `PLBM_OP_EXT);
    wire is_bit = (byte1 == `PLBM_OP_BIT_TOMEM) || (byte1 == `PLBM_OP_BIT_TOC);
    wire bit_tomem = (byte1 == `PLBM_OP_BIT_TOMEM);
    wire pair_ld = is_ext && (byte2[7:3] == 5'h1F) && !byte2[0];
    wire pair_st = is_ext && (byte2[7:3] == 5'h1E) && !byte2[0];

    reg [7:0] bit_addr;
    reg [2:0] bit_num;
    always @*
    begin
        bit_addr = 8'h00;
        bit_num = 3'h0;
        if (byte2[7:4] == `PLBM_BM_MEMB_TOP)
        begin
            bit_addr = {2'h3, byte2[3:0], primary_pointer_pair_q[3:2]};
            bit_num = {1'b0, primary_pointer_pair_q[1:0]};
        end
        else if (!byte2[7])
        begin
            bit_addr = {primary_pointer_pair_q[7:4], byte2[3:0]};
            bit_num = byte2[6:4];
        end
        // only the low byte of the port page address fits the 8-bit space
        else if (byte2[6])
        begin
            bit_addr = {`PLBM_MEMA_LO_B, byte2[3:0]};
            bit_num = {1'b0, byte2[5:4]};
        end
        else
        begin
            bit_addr = {`PLBM_MEMA_LO_A, byte2[3:0]};
            bit_num = {1'b0, byte2[5:4]};
        end
    end

    // ======================================================================
    // memory port steering
    always @*
    begin
        m_we = 1'b0;
        m_wa = 8'h00;
        m_wd = 4'h0;
        m_ra = mem_rd_addr;
        state_d = state_q;
        case (state_q)
            S_IDLE:
            begin
                if (mem_wr_en)
                begin
                    m_we = 1'b1;
                    m_wa = mem_wr_addr;
                    m_wd = mem_wr_data;
                end
                if (start)
                begin
                    state_d = S_IDLE;
                    m_we = 1'b0;
                    if (byte1 == `PLBM_OP_HL_A)
                    begin
                        m_we = 1'b1;
                        m_wa = primary_pointer_pair_q;
                        m_wd = wide_accumulator_q[3:0];
                    end
                    else if (is_ext && byte2 == `PLBM_EXT_HL_EA)
                    begin
                        m_we = 1'b1;
                        m_wa = hl_even;
                        m_wd = wide_accumulator_q[3:0];
                        state_d = S_ST2;
                    end
                    else if (byte1 == `PLBM_OP_DA_EA)
                    begin
                        m_we = 1'b1;
                        m_wa = da_even;
                        m_wd = wide_accumulator_q[3:0];
                        state_d = S_ST2;
                    end
                    else if (is_ext && byte2 == `PLBM_EXT_EA_HL)
                    begin
                        m_ra = hl_even;
                        state_d = S_LD1;
                    end
                    else if (byte1 == `PLBM_OP_EA_DA)
                    begin
                        m_ra = da_even;
                        state_d = S_LD1;
                    end
                    else if (is_bit)
                    begin
                        m_ra = bit_addr;
                        state_d = S_BIT;
                    end
                end
            end
            S_LD1:
            begin
                m_ra = {addr_q[7:1], 1'b1};
                state_d = S_LD2;
            end
            S_LD2:
            begin
                state_d = S_IDLE;
            end
            S_ST2:
            begin
                m_we = 1'b1;
                m_wa = {addr_q[7:1], 1'b1};
                m_wd = wide_accumulator_q[7:4];
                state_d = S_IDLE;
            end
            S_BIT:
            begin
                if (to_mem_q)
                begin
                    m_we = 1'b1;
                    m_wa = addr_q;
                    m_wd = m_rd;
                    m_wd[bit_q[1:0]] = carry_q;
                end
                state_d = S_IDLE;
            end
            default:
            begin
                state_d = S_IDLE;
            end
        endcase
    end

    // ======================================================================
    // sequencing and register updates
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= S_IDLE;
            addr_q <= 8'h00;
            bit_q <= 3'h0;
            to_mem_q <= 1'b0;
            done_q <= 1'b0;
            illegal_q <= 1'b0;
            wide_accumulator_q <= 8'h00;
            primary_pointer_pair_q <= 8'h00;
            second_pointer_pair_q <= 8'h00;
            third_pointer_pair_q <= 8'h00;
            carry_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            done_q <= 1'b0;
            illegal_q <= 1'b0;
            case (state_q)
                S_IDLE:
                begin
                    if (start)
                    begin
                        bit_q <= bit_num;
                        to_mem_q <= bit_tomem;
                        if (byte1 == `PLBM_OP_HL_A)
                        begin
                            done_q <= 1'b1;
                        end
                        else if (is_ext && byte2 == `PLBM_EXT_HL_EA)
                        begin
                            addr_q <= hl_even;
                        end
                        else if (byte1 == `PLBM_OP_DA_EA || byte1 == `PLBM_OP_EA_DA)
                        begin
                            addr_q <= da_even;
                        end
                        else if (is_ext && byte2 == `PLBM_EXT_EA_HL)
                        begin
                            addr_q <= hl_even;
                        end
                        else if (is_bit)
                        begin
                            addr_q <= bit_addr;
                        end
                        else if (pair_ld)
                        begin
                            done_q <= 1'b1;
                            case (byte2[2:1])
                                `PLBM_PAIR_HL: wide_accumulator_q <= primary_pointer_pair_q;
                                `PLBM_PAIR_WX: wide_accumulator_q <= second_pointer_pair_q;
                                `PLBM_PAIR_YZ: wide_accumulator_q <= third_pointer_pair_q;
                                default: wide_accumulator_q <= wide_accumulator_q;
                            endcase
                        end
                        else if (pair_st)
                        begin
                            done_q <= 1'b1;
                            case (byte2[2:1])
                                `PLBM_PAIR_HL: primary_pointer_pair_q <= wide_accumulator_q;
                                `PLBM_PAIR_WX: second_pointer_pair_q <= wide_accumulator_q;
                                `PLBM_PAIR_YZ: third_pointer_pair_q <= wide_accumulator_q;
                                default: third_pointer_pair_q <= third_pointer_pair_q;
                            endcase
                        end
                        else
                        begin
                            illegal_q <= 1'b1;
                        end
                    end
                end
                S_LD1:
                begin
                    wide_accumulator_q[3:0] <= m_rd;
                end
                S_LD2:
                begin
                    wide_accumulator_q[7:4] <= m_rd;
                    done_q <= 1'b1;
                end
                S_ST2:
                begin
                    done_q <= 1'b1;
                end
                S_BIT:
                begin
                    if (!to_mem_q)
                    begin
                        carry_q <= m_rd[bit_q[1:0]];
                    end
                    done_q <= 1'b1;
                end
                default:
                begin
                    done_q <= 1'b0;
                end
            endcase
        end
    end
endmodule // plbm_exec

/* File: dv/plbm_exec_sva.sv */
// assertions on the ports of the pair load and bit move execution block
// assumes it is bound onto plbm_exec and that the opcode header is on the path
`timescale 1ns/10ps
`include "plbm_consts.vh"
module plbm_exec_sva (
    input wire core_clk,
    input wire nrst,
    input wire start,
    input wire [7:0] byte1,
    input wire [7:0] byte2,
    input wire busy,
    input wire done_q,
    input wire illegal_q,
    input wire [7:0] wide_accumulator_q,
    input wire [7:0] primary_pointer_pair_q,
    input wire [7:0] second_pointer_pair_q,
    input wire carry_q
);
    // ======================================================================
    // properties
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    wire go = start && !busy;
    wire bit_op = byte1 == `PLBM_OP_BIT_TOMEM || byte1 == `PLBM_OP_BIT_TOC;
    sequence s_bit_go;
        go && bit_op;
    endsequence
    sequence s_two_step;
        !done_q ##1 done_q;
    endsequence
    a_bit_two_cycles: assert property (s_bit_go |=> s_two_step)
        else $error("bit move length wrong");
    a_pair_into_acc: assert property (go && byte1 == 8'hDC && byte2 == 8'hFA |=>
        wide_accumulator_q == $past(primary_pointer_pair_q)) else $error("pair copy wrong");
    a_acc_into_pair: assert property (go && byte1 == 8'hDC && byte2 == 8'hF4 |=>
        second_pointer_pair_q == $past(wide_accumulator_q)) else $error("acc copy wrong");
    a_pointer_kept: assert property (go && byte1 == 8'hDC && byte2 == 8'h08 |=>
        $stable(primary_pointer_pair_q)[*3]) else $error("pointer altered");
    a_pointer_store_kept: assert property (go && byte1 == 8'hDC && byte2 == 8'h00 |=>
        $stable(primary_pointer_pair_q)[*2]) else $error("pointer altered by store");
    a_carry_source: assert property (go && byte1 == 8'hFC |=> $stable(carry_q)[*2])
        else $error("carry altered by store");
    a_bit_no_side: assert property (s_bit_go |=>
        ($stable(wide_accumulator_q) && $stable(primary_pointer_pair_q))[*2])
        else $error("bit move touched registers");
    a_unknown_op: assert property (go && !bit_op && byte1 != 8'hDC && byte1 != 8'hCE
        && byte1 != 8'hCD && byte1 != 8'hC4 |=> illegal_q && !done_q)
        else $error("unknown opcode not refused");
    a_load_direct: assert property (go && byte1 == 8'hCE |=> !done_q ##1 s_two_step)
        else $error("direct load length wrong");
    a_store_direct: assert property (go && byte1 == 8'hCD |=> s_two_step)
        else $error("direct store length wrong");
endmodule // plbm_exec_sva

bind plbm_exec plbm_exec_sva i_sva (.core_clk(core_clk), .nrst(nrst), .start(start),
    .byte1(byte1), .byte2(byte2), .busy(busy), .done_q(done_q), .illegal_q(illegal_q),
    .wide_accumulator_q(wide_accumulator_q), .primary_pointer_pair_q(primary_pointer_pair_q),
    .second_pointer_pair_q(second_pointer_pair_q), .carry_q(carry_q));

/* File: dv/plbm_mem_agent.sv */
// backdoor agent standing for the data memory and port space side
// assumes it is used only while the block is idle, driving at falling edges
`timescale 1ns/10ps
module plbm_mem_agent (
    input wire core_clk,
    output logic mem_wr_en,
    output logic [7:0] mem_wr_addr,
    output logic [3:0] mem_wr_data,
    output logic [7:0] mem_rd_addr,
    input wire [3:0] mem_rd_data
);
    // ======================================================================
    // access tasks
    initial
    begin
        mem_wr_en = 1'b0;
        mem_wr_addr = 8'h00;
        mem_wr_data = 4'h0;
        mem_rd_addr = 8'h00;
    end
    // released lines show the inverse so a stale value never passes
    task automatic poke(input logic [7:0] a, input logic [3:0] v);
        @(negedge core_clk);
        mem_wr_en = 1'b1;
        mem_wr_addr = a;
        mem_wr_data = v;
        @(negedge core_clk);
        mem_wr_en = 1'b0;
        mem_wr_addr = ~a;
        mem_wr_data = ~v;
    endtask
    task automatic peek(input logic [7:0] a, output logic [3:0] v);
        @(negedge core_clk);
        mem_rd_addr = a;
        @(negedge core_clk);
        v = mem_rd_data;
    endtask
endmodule // plbm_mem_agent

/* File: dv/test_pair_load_and_bit_move_exec.sv */
// self-checking bench for the pair load and bit move execution block
// assumes the design under core/ and the backdoor agent beside this file
`timescale 1ns/10ps
`define CHK(g, e) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            num_errors++; \
            $display("[FAIL] %0t got %h exp %h", $time, g, e); \
        end \
    end
module test_pair_load_and_bit_move_exec;
    logic core_clk, nrst, start, busy, done_q, illegal_q, cy, mem_wr_en, bsy;
    logic [7:0] byte1, byte2, ea, hl, wx, yz, wa, ra;
    logic [3:0] wd, rd, d;
    int num_errors = 0;
    int samples_checked = 0;
    int n;
    plbm_exec i_dut (.core_clk(core_clk), .nrst(nrst), .start(start), .byte1(byte1),
        .byte2(byte2), .busy(busy), .done_q(done_q), .illegal_q(illegal_q),
        .wide_accumulator_q(ea), .primary_pointer_pair_q(hl), .second_pointer_pair_q(wx),
        .third_pointer_pair_q(yz), .carry_q(cy), .mem_wr_en(mem_wr_en), .mem_wr_addr(wa),
        .mem_wr_data(wd), .mem_rd_addr(ra), .mem_rd_data(rd));
    plbm_mem_agent i_mem (.core_clk(core_clk), .mem_wr_en(mem_wr_en), .mem_wr_addr(wa),
        .mem_wr_data(wd), .mem_rd_addr(ra), .mem_rd_data(rd));
    // ======================================================================
    // helpers
    task automatic op(input logic [7:0] b1, input logic [7:0] b2);
        @(negedge core_clk);
        start = 1'b1;
        byte1 = b1;
        byte2 = b2;
        @(negedge core_clk);
        start = 1'b0;
        bsy = busy;
        n = 1;
        while (done_q !== 1'b1 && illegal_q !== 1'b1 && n < 8)
        begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 8)
        begin
            num_errors++;
            $display("[FAIL] %0t op never finished", $time);
        end
    endtask
    task automatic chk_mem(input logic [7:0] a, input logic [3:0] e);
        i_mem.peek(a, d);
        `CHK(d, e)
    endtask
    task automatic set_ea(input logic [7:0] v);
        i_mem.poke(8'hE0, v[3:0]);
        i_mem.poke(8'hE1, v[7:4]);
        op(8'hCE, 8'hE0);
    endtask
    task automatic set_pair(input logic [1:0] rr, input logic [7:0] v);
        set_ea(v);
        op(8'hDC, {5'b11110, rr, 1'b0});
    endtask
    // ======================================================================
    // scenarios
    task automatic t_pairs;
        set_pair(2'h1, 8'h3C);
        `CHK(hl, 8'h3C)
        set_pair(2'h2, 8'h96);
        `CHK(wx, 8'h96)
        set_pair(2'h3, 8'hE1);
        `CHK(yz, 8'hE1)
        op(8'hDC, 8'hFC);
        `CHK(ea, 8'h96)
        op(8'hDC, 8'hFA);
        `CHK(ea, 8'h3C)
        `CHK(bsy, 1'b0)
        $display("t_pairs finished");
    endtask
    task automatic t_direct;
        i_mem.poke(8'h36, 4'hA);
        i_mem.poke(8'h37, 4'h3);
        op(8'hCE, 8'h37);
        `CHK(ea, 8'h3A)
        `CHK(bsy, 1'b1)
        op(8'hCD, 8'h45);
        chk_mem(8'h44, 4'hA);
        chk_mem(8'h45, 4'h3);
        $display("t_direct finished");
    endtask
    task automatic t_pointer;
        set_pair(2'h1, 8'h37);
        i_mem.poke(8'h36, 4'h9);
        i_mem.poke(8'h37, 4'h6);
        op(8'hDC, 8'h08);
        `CHK(ea, 8'h69)
        `CHK(hl, 8'h37)
        set_ea(8'hC5);
        op(8'hDC, 8'h00);
        chk_mem(8'h36, 4'h5);
        chk_mem(8'h37, 4'hC);
        set_ea(8'h0B);
        op(8'hC4, 8'h00);
        chk_mem(8'h37, 4'hB);
        chk_mem(8'h36, 4'h5);
        $display("t_pointer finished");
    endtask
    // pointer pair holds 37h here: upper 3h, lower 7h
    task automatic t_bits;
        i_mem.poke(8'hB5, 4'h4);
        op(8'hF4, 8'hA5);
        `CHK(n, 2)
        `CHK(bsy, 1'b1)
        `CHK(cy, 1'b1)
        chk_mem(8'hB5, 4'h4);
        i_mem.poke(8'hF3, 4'h0);
        op(8'hFC, 8'hD3);
        `CHK(n, 2)
        chk_mem(8'hF3, 4'h2);
        i_mem.poke(8'h39, 4'h0);
        op(8'hFC, 8'h39);
        chk_mem(8'h39, 4'h8);
        i_mem.poke(8'h3A, 4'hE);
        op(8'hF4, 8'h0A);
        `CHK(cy, 1'b0)
        i_mem.poke(8'hD9, 4'h8);
        op(8'hF4, 8'h46);
        `CHK(cy, 1'b1)
        op(8'hF4, 8'h0A);
        i_mem.poke(8'hD9, 4'hF);
        op(8'hFC, 8'h46);
        `CHK(n, 2)
        chk_mem(8'hD9, 4'h7);
        op(8'h00, 8'h00);
        `CHK(illegal_q, 1'b1)
        $display("t_bits finished");
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial
    begin
        nrst = 1'b0;
        start = 1'b0;
        byte1 = 8'h00;
        byte2 = 8'h00;
        repeat (16) @(negedge core_clk);
        nrst = 1'b1;
        t_pairs;
        t_direct;
        t_pointer;
        t_bits;
        final_report;
    end
    initial
    begin
        #50000;
        num_errors++;
        final_report;
    end
endmodule // test_pair_load_and_bit_move_exec
